// ### ssc_step_ctrl.sv
// Step address controller: sequencing, clock selection and Wishbone registers.
// Assumes all pin inputs are synchronous to clk_i and ce_i gates all state.
`timescale 1ns/10ps
module ssc_step_ctrl #(
   parameter int unsigned SKIP_CYC = ssc_pkg::SKIP_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_start_i,
   input  wire logic        ext_stop_i,
   input  wire logic        ext_reset_i,
   input  wire logic        ext_clk_i,
   input  wire logic        ext_clk_present_i,
   input  wire logic        ext_takeover_i,
   input  wire logic [2:0]  orig_addr_i,
   output logic             addr_bit_weight1_o,
   output logic             addr_bit_weight2_o,
   output logic             addr_bit_weight4_o,
   output logic             bank_select_bit_o,
   output logic             upper_bank_indicator_o,
   output logic [4:0]       mode_led_o,
   output logic             oneshot_led_o,
   output logic             clock_led_o,
   output logic             clock_out_o
);
   import ssc_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [31:0] m);
      return (old & ~m) | (nw & m);
   endfunction : merge

   ssc_ctrl_s   ctrl;
   ssc_run_e    run_st;
   logic [3:0]  first_q;
   logic [3:0]  last_q;
   logic [23:0] period_q;
   logic [23:0] width_q;
   logic [3:0]  cur;
   logic        dir;
   logic        rst_pend;
   logic [7:0]  lfsr;
   logic        start_d;
   logic        stop_d;
   logic        reset_d;
   logic        sclk_d;

   // Bus decode.
   logic [31:0] wmask;
   logic        req;
   logic        wr;
   logic        sel_ctrl;
   logic        sel_range;
   logic        sel_period;
   logic        sel_width;
   logic        sel_cmd;
   logic        sel_status;
   logic [31:0] next_rdata;
   logic [31:0] ctrl_word;
   logic [31:0] range_word;
   ssc_ctrl_s   ctrl_wr;
   ssc_status_s status;

   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
   end

   assign req        = wb_cyc_i & wb_stb_i;
   // Writes land at the edge where the master sees ack.
   assign wr         = req & wb_we_i & wb_ack_o;
   assign sel_ctrl   = (wb_adr_i == OFS_CTRL);
   assign sel_range  = (wb_adr_i == OFS_RANGE);
   assign sel_period = (wb_adr_i == OFS_PERIOD);
   assign sel_width  = (wb_adr_i == OFS_WIDTH);
   assign sel_cmd    = (wb_adr_i == OFS_CMD);
   assign sel_status = (wb_adr_i == OFS_STATUS);
   assign range_word = {20'h0_0000, last_q, 4'h0, first_q};
   assign ctrl_word  = {26'h000_0000, ctrl};

   // Merged write words, command strobes and pin edges.
   logic [31:0] ctrl_merged;
   logic [31:0] range_merged;
   logic [31:0] period_merged;
   logic [31:0] width_merged;
   logic        next_ack;
   logic        cmd_start;
   logic        cmd_stop;
   logic        cmd_reset;
   logic        cmd_step;
   logic        start_edge;
   logic        stop_edge;
   logic        reset_edge;

   // Clock selection and step sequencing.
   logic        gen_tick;
   logic        sel_clk;
   logic        tick;
   logic        adv;
   logic [3:0]  lo_st;
   logic [3:0]  hi_st;
   logic [3:0]  span_m1;
   logic        degenerate;
   logic [3:0]  home;
   logic        at_final;
   logic [3:0]  fwd_next;
   logic [3:0]  bwd_next;
   logic        pend_turn;
   logic        pend_dir;
   logic [3:0]  pend_next;
   logic [3:0]  rnd_off;
   logic [3:0]  rand_next;
   logic [3:0]  next_cur;
   logic        next_dir;
   ssc_run_e    next_run;
   logic        next_rst_pend;

   // Outputs and status.
   logic        eff_takeover;
   logic [3:0]  out_step;
   logic [4:0]  mode_onehot;
   logic [23:0] step_age;
   logic        skip;

   localparam logic [23:0] SKIP_AGE = 24'(SKIP_CYC);

   assign ctrl_merged   = merge(ctrl_word, wb_dat_i, wmask);
   assign range_merged  = merge(range_word, wb_dat_i, wmask);
   assign period_merged = merge({8'h00, period_q}, wb_dat_i, wmask);
   assign width_merged  = merge({8'h00, width_q}, wb_dat_i, wmask);
   assign ctrl_wr       = ssc_ctrl_s'(ctrl_merged[5:0]);

   assign status = {skip, eff_takeover, rst_pend, dir, (run_st == run_active), cur};

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (sel_ctrl) begin
         next_rdata = ctrl_word;
      end else if (sel_range) begin
         next_rdata = range_word;
      end else if (sel_period) begin
         next_rdata = {8'h00, period_q};
      end else if (sel_width) begin
         next_rdata = {8'h00, width_q};
      end else if (sel_status) begin
         next_rdata = {23'h00_0000, status};
      end
   end

   // One wait state: ack comes in the cycle after the request is seen,
   // and read data is loaded at the same edge so it stands with ack.
   assign next_ack = req & ~wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= next_ack;
         if (next_ack) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl     <= ssc_ctrl_s'(CTRL_RST);
         first_q  <= FIRST_RST;
         last_q   <= LAST_RST;
         period_q <= PERIOD_RST;
         width_q  <= WIDTH_RST;
      end else if (ce_i && wr) begin
         if (sel_ctrl) begin
            ctrl <= ctrl_wr;
         end
         if (sel_range) begin
            first_q <= range_merged[RNG_FIRST_LSB +: 4];
            last_q  <= range_merged[RNG_LAST_LSB +: 4];
         end
         if (sel_period) begin
            period_q <= period_merged[23:0];
         end
         if (sel_width) begin
            width_q <= width_merged[23:0];
         end
      end
   end

   // Command writes act like the front buttons.
   assign cmd_start  = wr & sel_cmd & wb_sel_i[0] & wb_dat_i[CMD_START_BIT];
   assign cmd_stop   = wr & sel_cmd & wb_sel_i[0] & wb_dat_i[CMD_STOP_BIT];
   assign cmd_reset  = wr & sel_cmd & wb_sel_i[0] & wb_dat_i[CMD_RESET_BIT];
   assign cmd_step   = wr & sel_cmd & wb_sel_i[0] & wb_dat_i[CMD_STEP_BIT];
   assign start_edge = (ext_start_i & ~start_d) | cmd_start;
   assign stop_edge  = (ext_stop_i & ~stop_d) | cmd_stop;
   assign reset_edge = (ext_reset_i & ~reset_d) | cmd_reset;

   ssc_clock_gen u_clk_gen (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .period_i (period_q),
      .width_i  (width_q),
      .tick_o   (gen_tick)
   );

   // The internal clock stands in whenever no external clock is plugged in.
   assign sel_clk = ext_clk_present_i ? ext_clk_i : gen_tick;
   assign tick    = (sel_clk & ~sclk_d) | cmd_step;
   assign adv     = tick & (run_st == run_active);

   // In parallel operation both sequencers share the low three bits.
   assign lo_st      = ctrl.serial ? first_q : {1'b0, first_q[2:0]};
   assign hi_st      = ctrl.serial ? last_q : {1'b0, last_q[2:0]};
   assign degenerate = (hi_st <= lo_st);
   assign span_m1    = hi_st - lo_st;
   // A backward run starts from its top end.
   assign home       = (ctrl.mode == mode_bwd && !degenerate) ? hi_st : lo_st;

   assign at_final = ctrl.oneshot & ~degenerate &
                     ((((ctrl.mode == mode_fwd) || (ctrl.mode == mode_rand)) &&
                       (cur == hi_st)) ||
                      ((ctrl.mode == mode_bwd) && (cur == lo_st)) ||
                      ((ctrl.mode == mode_pend) && dir && (cur == lo_st)));

   assign fwd_next  = (cur >= hi_st || cur < lo_st) ? lo_st : cur + 4'h1;
   assign bwd_next  = (cur <= lo_st || cur > hi_st) ? hi_st : cur - 4'h1;
   assign pend_turn = dir ? (cur <= lo_st) : (cur >= hi_st);
   assign pend_dir  = pend_turn ? ~dir : dir;
   assign pend_next = (cur < lo_st || cur > hi_st) ? lo_st :
                      (pend_dir ? cur - 4'h1 : cur + 4'h1);
   // The modulo keeps random picks inside the range at the cost of a
   // slight bias towards the low steps.
   assign rnd_off   = 4'(({1'b0, lfsr[3:0]}) % ({1'b0, span_m1} + 5'h01));
   assign rand_next = lo_st + rnd_off;

   always_comb begin
      next_run = run_st;
      case (run_st)
         run_idle: begin
            if (start_edge && !stop_edge) begin
               next_run = run_active;
            end
         end
         run_active: begin
            if (stop_edge) begin
               next_run = run_idle;
            end else if (adv && at_final && !rst_pend && ctrl.mode != mode_cv) begin
               next_run = run_idle;
            end
         end
         default: begin
            next_run = run_idle;
         end
      endcase
   end

   always_comb begin
      next_cur = cur;
      next_dir = dir;
      if (ctrl.mode == mode_cv) begin
         next_cur = lo_st;
      end else if (tick && rst_pend) begin
         next_cur = home;
         next_dir = 1'b0;
      end else if (adv && degenerate) begin
         next_cur = lo_st;
      end else if (adv && !at_final) begin
         case (ctrl.mode)
            mode_bwd: begin
               next_cur = bwd_next;
            end
            mode_pend: begin
               next_cur = pend_next;
               next_dir = pend_dir;
            end
            mode_rand: begin
               next_cur = rand_next;
            end
            default: begin
               next_cur = fwd_next;
            end
         endcase
      end
   end

   // A reset edge in the same cycle as a clock edge stays pending.
   assign next_rst_pend = reset_edge ? 1'b1 : (tick ? 1'b0 : rst_pend);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_st   <= run_idle;
         cur      <= 4'h0;
         dir      <= 1'b0;
         rst_pend <= 1'b0;
         lfsr     <= LFSR_SEED;
         start_d  <= 1'b0;
         stop_d   <= 1'b0;
         reset_d  <= 1'b0;
         sclk_d   <= 1'b0;
         step_age <= 24'h00_0000;
         skip     <= 1'b0;
      end else if (ce_i) begin
         run_st   <= next_run;
         cur      <= next_cur;
         dir      <= next_dir;
         rst_pend <= next_rst_pend;
         lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         start_d  <= ext_start_i;
         stop_d   <= ext_stop_i;
         reset_d  <= ext_reset_i;
         sclk_d   <= sel_clk;
         if (adv) begin
            step_age <= 24'h00_0000;
            skip     <= (step_age < SKIP_AGE);
         end else if (step_age != 24'hff_ffff) begin
            step_age <= step_age + 24'h00_0001;
         end
      end
   end

   assign eff_takeover = ctrl.takeover | ext_takeover_i;
   assign out_step     = eff_takeover ? {ctrl.serial & cur[3], cur[2:0]} :
                         {1'b0, orig_addr_i};

   for (genvar m = 0; m < 5; m++) begin : g_mode_led
      assign mode_onehot[m] = (ctrl.mode == ssc_mode_e'(3'(m)));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_bit_weight1_o     <= 1'b0;
         addr_bit_weight2_o     <= 1'b0;
         addr_bit_weight4_o     <= 1'b0;
         bank_select_bit_o      <= 1'b0;
         upper_bank_indicator_o <= 1'b0;
         mode_led_o             <= 5'h00;
         oneshot_led_o          <= 1'b0;
         clock_led_o            <= 1'b0;
         clock_out_o            <= 1'b0;
      end else if (ce_i) begin
         addr_bit_weight1_o     <= out_step[0];
         addr_bit_weight2_o     <= out_step[1];
         addr_bit_weight4_o     <= out_step[2];
         bank_select_bit_o      <= out_step[3];
         upper_bank_indicator_o <= out_step[3];
         mode_led_o             <= mode_onehot;
         oneshot_led_o          <= ctrl.oneshot & (ctrl.mode != mode_cv);
         clock_led_o            <= gen_tick;
         clock_out_o            <= gen_tick;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_addr_follows: assert property (ce_i && eff_takeover |=>
      {addr_bit_weight4_o, addr_bit_weight2_o, addr_bit_weight1_o} == $past(out_step[2:0]))
      else $error("address lines do not follow the step");

   a_orig_passes: assert property (ce_i && !eff_takeover |=>
      {addr_bit_weight4_o, addr_bit_weight2_o, addr_bit_weight1_o} == $past(orig_addr_i))
      else $error("original address not passed through");

   a_bank_parallel: assert property (ce_i && !ctrl.serial |=> !bank_select_bit_o)
      else $error("bank bit set in parallel operation");

   a_cv_first: assert property (ce_i && ctrl.mode == mode_cv |=> cur == $past(lo_st))
      else $error("voltage mode step differs from first setting");

   a_oneshot_halts: assert property (ce_i && ctrl.mode != mode_cv && adv && at_final
      && !rst_pend && !stop_edge |=> run_st == run_idle && $stable(cur))
      else $error("one-shot run did not halt on its final step");

   a_range_kept: assert property (ce_i && ctrl.mode != mode_cv && adv && !rst_pend
      && !degenerate && cur >= lo_st && cur <= hi_st
      |=> cur >= $past(lo_st) && cur <= $past(hi_st))
      else $error("step left the first to last range");

   a_reset_waits: assert property (ce_i && reset_edge && !tick
      && ctrl.mode != mode_cv |=> $stable(cur))
      else $error("reset request moved the step before a clock edge");

   c_oneshot_halt: cover property (adv && at_final && run_st == run_active);
   c_pend_turn: cover property (adv && ctrl.mode == mode_pend && pend_turn);
   c_upper_bank: cover property (bank_select_bit_o);
   c_skip_seen: cover property (skip);

endmodule : ssc_step_ctrl

// ### ssc_pkg.sv
// What this block does
// - Step drives three binary lines, weights 1,2,4.
// - Four running modes, each loop or one-shot.
// - Five mode indicators plus one one-shot indicator.
// - Step order follows mode and loop setting.
// - First and last step confine the sequence.
// - Voltage mode: first setting is the step.
// - Serial operation adds bank bit of weight 8.
// - Selectable 8-step parallel or 16-step serial.
// - Bank bit on output and indicator.
// - Internal clock with independent rate and width.
// - Clock indicator follows generated clock level.
// - Very short step time effectively skips step.
// - Takeover chooses original unit or this block.
// - Rising start starts, rising stop halts.
// - Advance on selected clock rising edge.
// - Reset request waits for next clock edge.
// - One-shot halts on the final step.
// Constants, types and register layout of the step address controller.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone slave.
package ssc_pkg;

   localparam int unsigned CLK_PERIOD_NS = 5;
   // A step shorter than this counts as skipped.
   localparam int unsigned SKIP_TIME_NS  = 1000000;
   localparam int unsigned SKIP_CYC      = SKIP_TIME_NS / CLK_PERIOD_NS;

   localparam logic [4:0] OFS_CTRL   = 5'h00;
   localparam logic [4:0] OFS_RANGE  = 5'h04;
   localparam logic [4:0] OFS_PERIOD = 5'h08;
   localparam logic [4:0] OFS_WIDTH  = 5'h0c;
   localparam logic [4:0] OFS_CMD    = 5'h10;
   localparam logic [4:0] OFS_STATUS = 5'h14;

   localparam int unsigned RNG_FIRST_LSB = 0;
   localparam int unsigned RNG_LAST_LSB  = 8;
   localparam int unsigned CMD_START_BIT = 0;
   localparam int unsigned CMD_STOP_BIT  = 1;
   localparam int unsigned CMD_RESET_BIT = 2;
   localparam int unsigned CMD_STEP_BIT  = 3;

   localparam logic [5:0]  CTRL_RST   = 6'h00;
   localparam logic [3:0]  FIRST_RST  = 4'h0;
   localparam logic [3:0]  LAST_RST   = 4'hf;
   localparam logic [23:0] PERIOD_RST = 24'h10_0000;
   localparam logic [23:0] WIDTH_RST  = 24'h08_0000;
   localparam logic [23:0] MIN_PERIOD = 24'h00_0002;
   localparam logic [7:0]  LFSR_SEED  = 8'he1;

   typedef enum logic [2:0] {
      mode_fwd  = 3'b000,
      mode_bwd  = 3'b001,
      mode_pend = 3'b010,
      mode_rand = 3'b011,
      mode_cv   = 3'b100
   } ssc_mode_e;

   typedef enum logic {
      run_idle   = 1'b0,
      run_active = 1'b1
   } ssc_run_e;

   typedef struct packed {
      logic      takeover;
      logic      serial;
      logic      oneshot;
      ssc_mode_e mode;
   } ssc_ctrl_s;

   typedef struct packed {
      logic       skip;
      logic       takeover;
      logic       rst_pend;
      logic       dir_down;
      logic       running;
      logic [3:0] step;
   } ssc_status_s;

endpackage : ssc_pkg

// ### ssc_clock_gen.sv
// Internal step clock generator with programmable period and high time.
// Assumes period and width are stable registers of the system clock domain.
`timescale 1ns/10ps
module ssc_clock_gen (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic [23:0] period_i,
   input  wire logic [23:0] width_i,
   output logic             tick_o
);
   import ssc_pkg::*;

   logic [23:0] cnt;
   logic [23:0] eff_period;
   logic [23:0] eff_width;
   logic [23:0] last_cnt;

   // Clamping keeps at least one low and one high cycle, so even the
   // shortest period still yields an edge and the step is passed over.
   assign eff_period = (period_i < MIN_PERIOD) ? MIN_PERIOD : period_i;
   assign last_cnt   = eff_period - 24'h00_0001;
   assign eff_width  = (width_i == 24'h00_0000) ? 24'h00_0001 :
                       (width_i > last_cnt) ? last_cnt : width_i;

   // Rate and high time are independent settings.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt    <= 24'h00_0000;
         tick_o <= 1'b0;
      end else if (ce_i) begin
         cnt    <= (cnt >= last_cnt) ? 24'h00_0000 : cnt + 24'h00_0001;
         tick_o <= (cnt >= last_cnt) ? 1'b1 : (cnt + 24'h00_0001 < eff_width);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_gen_has_edge: assert property (ce_i && cnt == last_cnt && eff_width < last_cnt
      |=> tick_o)
      else $error("clock generator missed its rising phase");

endmodule : ssc_clock_gen

// ### ssc_seq_model.sv
// Model of the sequencer's step select input, fed by the address lines.
// Assumes the lines settle within one system clock.
`timescale 1ns/10ps
module ssc_seq_model (
   input  wire logic       w1_i,
   input  wire logic       w2_i,
   input  wire logic       w4_i,
   input  wire logic       w8_i,
   output logic [3:0]      step_o
);
   // Bank bit of weight 8 picks the second unit.
   assign step_o = {w8_i, w4_i, w2_i, w1_i};
endmodule : ssc_seq_model

// ### ssc_step_ctrl_tb.sv
// Self-checking bench of the step address controller with a sequencer model.
// Assumes a classic Wishbone slave and pin inputs synchronous to clk_i.
`timescale 1ns/10ps
module ssc_step_ctrl_tb;
   import ssc_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, tko = 0, prs = 1;
   logic [4:0]  adr = 0, mled;
   logic [31:0] wd = 0, rd;
   logic [3:0]  pins = 0, st;
   logic [2:0]  orig = 3'h5;
   logic        w1, w2, w4, w8, ubi, oled, cled, cout;
   int          mismatches = 0, checks = 0, hi;
   always #2.5 clk_i = ~clk_i;
   ssc_step_ctrl #(.SKIP_CYC(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .ext_start_i(pins[1]),
      .ext_stop_i(pins[2]), .ext_reset_i(pins[3]), .ext_clk_i(pins[0]),
      .ext_clk_present_i(prs), .ext_takeover_i(tko), .orig_addr_i(orig),
      .addr_bit_weight1_o(w1), .addr_bit_weight2_o(w2), .addr_bit_weight4_o(w4),
      .bank_select_bit_o(w8), .upper_bank_indicator_o(ubi), .mode_led_o(mled),
      .oneshot_led_o(oled), .clock_led_o(cled), .clock_out_o(cout));
   ssc_seq_model SEQ (.w1_i(w1), .w2_i(w2), .w4_i(w4), .w8_i(w8), .step_o(st));
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         close_out();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   // Pulses stay well apart so no step counts as skipped.
   task automatic pin(input int b);
      pins[b] <= 1'b1;
      repeat (3) @(posedge clk_i);
      pins[b] <= 1'b0;
      repeat (20) @(posedge clk_i);
   endtask : pin
   task automatic cfg(input logic [5:0] c, input logic [3:0] f, input logic [3:0] l);
      wb(1'b1, OFS_CTRL, {26'h0, c});
      wb(1'b1, OFS_RANGE, {20'h0, l, 4'h0, f});
      pin(3);
   endtask : cfg
   task automatic t_over();
      chk(st[2:0], orig);
      wb(1'b0, OFS_RANGE, 0);
      chk(rd[11:0], {LAST_RST, 4'h0, FIRST_RST});
      wb(1'b0, 5'h18, 0);
      $display("takeover test done");
   endtask : t_over
   task automatic t_run();
      cfg(6'h20, 2, 5);
      pin(1);
      for (int i = 0; i < 5; i++) begin
         pin(0);
         chk(st, 2 + i % 4);
      end
      chk({oled, mled}, 6'h01);
      pin(2);
      pin(0);
      chk(st, 4'h2);
      pin(1);
      cfg(6'h21, 2, 5);
      for (int i = 0; i < 4; i++) begin
         pin(0);
         chk(st, 5 - i);
      end
      $display("loop test done");
   endtask : t_run
   task automatic t_one();
      cfg(6'h28, 2, 5);
      for (int i = 0; i < 5; i++) begin
         pin(0);
         chk(st, i < 3 ? 2 + i : 5);
      end
      chk({oled, mled}, 6'h21);
      pin(1);
      cfg(6'h24, 6, 1);
      pin(0);
      chk(st, 4'h6);
      cfg(6'h20, 3, 3);
      pin(0);
      pin(0);
      chk(st, 4'h3);
      $display("one-shot test done");
   endtask : t_one
   task automatic t_pend();
      cfg(6'h22, 2, 4);
      for (int i = 0; i < 6; i++) begin
         pin(0);
         chk(st, i < 3 ? 2 + i : (i < 5 ? 6 - i : 3));
      end
      chk(mled, 5'h04);
      cfg(6'h23, 2, 4);
      pin(0);
      for (int i = 0; i < 6; i++) begin
         pin(0);
         chk(st >= 2 && st <= 4, 1);
      end
      chk(mled, 5'h08);
      $display("pendulum and random test done");
   endtask : t_pend
   task automatic t_ser();
      cfg(6'h30, 6, 9);
      for (int i = 0; i < 5; i++) begin
         pin(0);
         chk({ubi, st}, {i == 2 || i == 3, 4'(6 + i % 4)});
      end
      wb(1'b1, OFS_PERIOD, 20);
      wb(1'b1, OFS_WIDTH, 5);
      prs <= 1'b0;
      repeat (45) @(posedge clk_i);
      hi = 0;
      repeat (40) begin
         @(posedge clk_i);
         hi += cout;
         chk(cled, cout);
      end
      chk(hi, 10);
      wb(1'b0, OFS_STATUS, 0);
      chk(rd[8], 1'b0);
      wb(1'b1, OFS_PERIOD, 2);
      repeat (10) @(posedge clk_i);
      wb(1'b0, OFS_STATUS, 0);
      chk(rd[8], 1'b1);
      $display("serial and clock test done");
   endtask : t_ser
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_over();
      tko <= 1'b1;
      t_run();
      t_one();
      t_pend();
      t_ser();
      close_out();
   end
endmodule : ssc_step_ctrl_tb
